// *** ulcs_pkg.sv ***
// package: register map, field positions, reset values and carrier structs for the line control/status block
package ulcs_pkg;
   // register byte addresses on the axi4-lite bus
   localparam logic [5:0] ULCS_OFF_DATA = 6'h00;   // rx buffer / tx holding, divisor low with access select
   localparam logic [5:0] ULCS_OFF_IEN = 6'h04;    // interrupt enable, divisor high with access select
   localparam logic [5:0] ULCS_OFF_IDENT = 6'h08;  // interrupt ident (read) / fifo control (write)
   localparam logic [5:0] ULCS_OFF_LCR = 6'h0C;    // line_format_control
   localparam logic [5:0] ULCS_OFF_LSR = 6'h14;    // line_condition_status
   localparam logic [5:0] ULCS_OFF_RXIN = 6'h20;   // receive-side character injection
   localparam logic [5:0] ULCS_OFF_TXCT = 6'h24;   // transmit-side progress control
   localparam logic [5:0] ULCS_OFF_TXST = 6'h28;   // transmitter state / serial line view
   // line control field positions
   localparam int ULCS_LC_STOP = 2;
   localparam int ULCS_LC_PEN = 3;
   localparam int ULCS_LC_EPS = 4;
   localparam int ULCS_LC_STICK = 5;
   localparam int ULCS_LC_BRK = 6;
   localparam int ULCS_LC_DIVISOR_ACCESS_SELECT = 7;
   // interrupt enable field positions
   localparam int ULCS_IE_RX = 0;
   localparam int ULCS_IE_HOLDING_EMPTY_FLAG = 1;
   localparam int ULCS_IE_LS = 2;
   localparam int ULCS_IE_MS = 3;
   // rx injection word field positions
   localparam int ULCS_RI_PAR = 8;
   localparam int ULCS_RI_STOP = 9;
   localparam int ULCS_RI_BRK = 10;
   localparam int ULCS_RI_TMO = 11;
   localparam int ULCS_RI_MS = 12;
   // reset values
   localparam logic [7:0] ULCS_LCR_RST = 8'h00;
   localparam logic [7:0] ULCS_IER_RST = 8'h00;
   localparam logic [15:0] ULCS_DIV_RST = 16'h0000;
   localparam logic [7:0] ULCS_LSR_RST = 8'h60;    // holding empty and transmitter idle
   // identification codes and bus response codes
   localparam logic [3:0] ULCS_ID_NONE = 4'h1;
   localparam logic [3:0] ULCS_ID_LS = 4'h6;
   localparam logic [3:0] ULCS_ID_RXD = 4'h4;
   localparam logic [3:0] ULCS_ID_TMO = 4'hC;
   localparam logic [3:0] ULCS_ID_HOLDING_EMPTY_FLAG = 4'h2;
   localparam logic [3:0] ULCS_ID_MS = 4'h0;
   localparam logic [1:0] ULCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] ULCS_RESP_SLVERR = 2'h2;

   // one stored receive character with its error marks
   typedef struct packed {
      logic brk;
      logic frm;
      logic par;
      logic [7:0] data;
   } ulcs_rx_entry_t;

   // line status flags as held
   typedef struct packed {
      logic fifo_err;
      logic tx_idle;
      logic holding_empty;
      logic brk;
      logic frm;
      logic par;
      logic overrun;
      logic rx_ready;
   } ulcs_status_t;
endpackage : ulcs_pkg

// *** ulcs_line_ctrl.sv ***
// top: register logic of one serial channel (ident, line control, line status) on axi4-lite
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module ulcs_line_ctrl
   import ulcs_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic serial_out,
   output logic interrupt_output
);
   // bus channel state
   logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
   logic [5:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   // channel registers
   logic [7:0] lcr_reg, lcr_next, ier_reg, ier_next;
   logic [15:0] div_reg, div_next;
   logic fifo_en_reg, fifo_en_next, tmo_reg, tmo_next, ms_reg, ms_next;
   ulcs_status_t st_reg, st_next;
   logic [7:0] rbr_reg, rbr_next, thr_reg, thr_next, tsr_reg, tsr_next;
   logic thr_full_reg, thr_full_next, tsr_busy_reg, tsr_busy_next;
   logic holding_empty_flag_ack_reg, holding_empty_flag_ack_next, so_reg, so_next, irq_reg, irq_next;
   // receive fifo storage and transmit tick counter
   ulcs_rx_entry_t fifo_mem [DEPTH];
   logic [AW-1:0] rp_reg, rp_next, wp_reg, wp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic [DEPTH-1:0] errv_reg, errv_next;
   logic [AW:0] txc_reg, txc_next;

   // access decode: a write fires once address and data have both arrived
   logic wr_fire, rd_fire;
   logic [5:0] ra;
   logic [7:0] wb;
   logic [15:0] wx;
   ulcs_rx_entry_t head, inj;
   logic [3:0] ident;
   logic ls_pend, rx_pend, holding_empty_flag_pend, pend, lsr_rd, rbr_rd, iir_rd;
   logic [7:0] lsr_view, wmask;
   logic par_exp, stick_val;
   assign wr_fire = aw_reg && w_reg && !b_reg;
   assign rd_fire = s_axi_arvalid && !r_reg;
   assign ra = s_axi_araddr;
   assign wb = wd_reg[7:0];
   assign wx = wd_reg[15:0];
   assign head = fifo_mem[rp_reg];
   assign inj = ulcs_rx_entry_t'({wx[ULCS_RI_BRK], wx[ULCS_RI_STOP] == 1'b0, 1'b0, wx[7:0]});
   assign lsr_rd = rd_fire && ra == ULCS_OFF_LSR;
   assign rbr_rd = rd_fire && ra == ULCS_OFF_DATA && !lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT];
   assign iir_rd = rd_fire && ra == ULCS_OFF_IDENT;
   // word-length mask, 5..8 bits
   assign wmask = 8'hFF >> (2'h3 - lcr_reg[1:0]);

   // expected parity of the injected character: even when bit4 set, stick forces ~bit4
   always_comb begin
      par_exp = ^(wx[7:0] & wmask) ^ ~lcr_reg[ULCS_LC_EPS];
      stick_val = ~lcr_reg[ULCS_LC_EPS];
      if (lcr_reg[ULCS_LC_STICK]) begin
         par_exp = stick_val;
      end
   end

   // status view: in fifo mode error bits come from the head character
   always_comb begin
      lsr_view = st_reg;
      if (fifo_en_reg) begin
         lsr_view[2] = st_reg.par | (cnt_reg != '0 && head.par);
         lsr_view[3] = st_reg.frm | (cnt_reg != '0 && head.frm);
         lsr_view[4] = st_reg.brk | (cnt_reg != '0 && head.brk);
         lsr_view[7] = |errv_reg;
      end else begin
         lsr_view[7] = 1'b0;
      end
   end

   // interrupt priority: line status, rx data/timeout, holding empty, modem
   always_comb begin
      ls_pend = ier_reg[ULCS_IE_LS] && (|lsr_view[4:1]);
      rx_pend = ier_reg[ULCS_IE_RX] && (st_reg.rx_ready || tmo_reg);
      holding_empty_flag_pend = ier_reg[ULCS_IE_HOLDING_EMPTY_FLAG] && st_reg.holding_empty && !holding_empty_flag_ack_reg;
      pend = ls_pend || rx_pend || holding_empty_flag_pend || (ier_reg[ULCS_IE_MS] && ms_reg);
      if (ls_pend) begin
         ident = ULCS_ID_LS;
      end else if (rx_pend) begin
         ident = (tmo_reg && fifo_en_reg) ? ULCS_ID_TMO : ULCS_ID_RXD;
      end else if (holding_empty_flag_pend) begin
         ident = ULCS_ID_HOLDING_EMPTY_FLAG;
      end else if (pend) begin
         ident = ULCS_ID_MS;
      end else begin
         ident = ULCS_ID_NONE;
      end
   end

   // axi handshake and register next state
   always_comb begin
      aw_next = aw_reg;
      w_next = w_reg;
      b_next = b_reg;
      r_next = r_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      bresp_next = bresp_reg;
      rresp_next = rresp_reg;
      lcr_next = lcr_reg;
      ier_next = ier_reg;
      div_next = div_reg;
      fifo_en_next = fifo_en_reg;
      tmo_next = tmo_reg;
      ms_next = ms_reg;
      st_next = st_reg;
      rbr_next = rbr_reg;
      thr_next = thr_reg;
      tsr_next = tsr_reg;
      thr_full_next = thr_full_reg;
      tsr_busy_next = tsr_busy_reg;
      holding_empty_flag_ack_next = holding_empty_flag_ack_reg;
      rp_next = rp_reg;
      wp_next = wp_reg;
      cnt_next = cnt_reg;
      errv_next = errv_reg;
      txc_next = txc_reg;
      if (s_axi_awvalid && !aw_reg) begin
         aw_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_reg) begin
         w_next = 1'b1;
         wd_next = s_axi_wdata;
      end
      if (b_reg && s_axi_bready) begin
         b_next = 1'b0;
      end
      if (r_reg && s_axi_rready) begin
         r_next = 1'b0;
      end
      // reads: side effects happen here, in the accept cycle
      if (rd_fire) begin
         r_next = 1'b1;
         rresp_next = ULCS_RESP_OKAY;
         case (ra)
            ULCS_OFF_DATA: rd_next = {24'h0, lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT] ? div_reg[7:0]
                                      : (fifo_en_reg ? head.data : rbr_reg)};
            ULCS_OFF_IEN: rd_next = {24'h0, lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT] ? div_reg[15:8] : ier_reg};
            ULCS_OFF_IDENT: rd_next = {24'h0, {2{fifo_en_reg}}, 2'b00, ident};
            ULCS_OFF_LCR: rd_next = {24'h0, lcr_reg};
            ULCS_OFF_LSR: rd_next = {24'h0, lsr_view};
            ULCS_OFF_TXST: rd_next = {27'h0, txc_reg == '0, so_reg, tsr_busy_reg, thr_full_reg, cnt_reg != '0};
            default: begin
               rd_next = 32'h0;
               rresp_next = ULCS_RESP_SLVERR;
            end
         endcase
      end
      // status read clears error flags; sets below come after and win
      if (lsr_rd) begin
         st_next.overrun = 1'b0;
         st_next.par = 1'b0;
         st_next.frm = 1'b0;
         st_next.brk = 1'b0;
         if (fifo_en_reg && cnt_reg != '0) begin
            errv_next[rp_reg] = 1'b0; // head error seen; clears once none remain
         end
      end
      if (iir_rd && ident == ULCS_ID_HOLDING_EMPTY_FLAG) begin
         holding_empty_flag_ack_next = 1'b1;
      end
      if (rbr_rd) begin
         tmo_next = 1'b0;
         if (fifo_en_reg) begin
            if (cnt_reg != '0) begin
               rp_next = rp_reg + 1'b1;
               cnt_next = cnt_reg - 1'b1;
               errv_next[rp_reg] = 1'b0;
            end
            st_next.rx_ready = (cnt_reg > 1);
         end else begin
            st_next.rx_ready = 1'b0;
         end
      end
      // transmit progress: holding moves to shift, shift drains on host strobe
      if (thr_full_reg && !tsr_busy_reg) begin
         tsr_next = thr_reg;
         tsr_busy_next = 1'b1;
         thr_full_next = 1'b0;
         st_next.holding_empty = 1'b1;
         holding_empty_flag_ack_next = 1'b0;
         // one stop bit normally, two when the stop bit is set; 1.5 for 5-bit words counted as one extra tick
         txc_next = (AW+1)'(1 + int'(lcr_reg[1:0]) + 5 + int'(lcr_reg[ULCS_LC_PEN])
                    + (lcr_reg[ULCS_LC_STOP] ? 2 : 1));
      end
      if (wr_fire) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         b_next = 1'b1;
         bresp_next = ULCS_RESP_OKAY;
         case (awa_reg)
            ULCS_OFF_DATA: begin
               if (lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT]) begin
                  div_next[7:0] = wb;
               end else if (!thr_full_reg) begin
                  thr_next = wb;
                  thr_full_next = 1'b1;
                  st_next.holding_empty = 1'b0;
                  st_next.tx_idle = 1'b0;
               end
            end
            ULCS_OFF_IEN: begin
               if (lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT]) begin
                  div_next[15:8] = wb;
               end else begin
                  ier_next = {4'h0, wb[3:0]};
               end
            end
            ULCS_OFF_IDENT: fifo_en_next = wb[0];
            ULCS_OFF_LCR: lcr_next = wb;
            ULCS_OFF_TXCT: begin
               if (tsr_busy_reg && txc_reg != '0) begin
                  txc_next = txc_reg - 1'b1;
               end
            end
            ULCS_OFF_RXIN: begin
               tmo_next = wx[ULCS_RI_TMO] && fifo_en_reg && cnt_reg != '0;
               ms_next = wx[ULCS_RI_MS];
               if (wx[8] || wx[ULCS_RI_BRK] || wx[ULCS_RI_STOP] == 1'b0 || 1'b1) begin
                  // a break arrives as one zero character
                  if (fifo_en_reg) begin
                     if (cnt_reg == (AW+1)'(DEPTH)) begin
                        st_next.overrun = 1'b1;
                     end else begin
                        wp_next = wp_reg + 1'b1;
                        cnt_next = cnt_next + 1'b1;
                        errv_next[wp_reg] = 1'b0;
                        st_next.rx_ready = 1'b1;
                     end
                  end else begin
                     if (st_reg.rx_ready && !rbr_rd) begin
                        st_next.overrun = 1'b1;
                     end
                     rbr_next = wx[ULCS_RI_BRK] ? 8'h00 : (wx[7:0] & wmask);
                     st_next.rx_ready = 1'b1;
                     st_next.par = st_next.par | (lcr_reg[ULCS_LC_PEN] && wx[ULCS_RI_PAR] != par_exp);
                     st_next.frm = st_next.frm | (!wx[ULCS_RI_STOP] && !wx[ULCS_RI_BRK]);
                     st_next.brk = st_next.brk | wx[ULCS_RI_BRK];
                  end
               end
            end
            ULCS_OFF_LSR: st_next = ulcs_status_t'(wb);
            default: bresp_next = ULCS_RESP_SLVERR;
         endcase
      end
      // shift register finished; a waiting holding byte moves on the next cycle, never a stall
      if (tsr_busy_reg && txc_reg == '0) begin
         tsr_busy_next = 1'b0;
         st_next.tx_idle = !thr_full_next;
      end
      if (!fifo_en_reg) begin
         st_next.fifo_err = 1'b0;
         errv_next = '0;
      end
   end

   // receive fifo write with per-character error marks
   logic fifo_push;
   ulcs_rx_entry_t push_ent;
   logic push_err;
   always_comb begin
      push_ent = inj;
      push_ent.data = inj.brk ? 8'h00 : (wx[7:0] & wmask);
      push_ent.par = lcr_reg[ULCS_LC_PEN] && !inj.brk && wx[ULCS_RI_PAR] != par_exp;
      push_ent.frm = inj.frm && !inj.brk;
      push_err = push_ent.par || push_ent.frm || push_ent.brk;
      fifo_push = wr_fire && awa_reg == ULCS_OFF_RXIN && fifo_en_reg && cnt_reg != (AW+1)'(DEPTH);
   end

   always_ff @(posedge sys_clk) begin
      if (fifo_push) begin
         fifo_mem[wp_reg] <= push_ent;
      end
   end

   // serial output and interrupt line
   always_comb begin
      so_next = lcr_reg[ULCS_LC_BRK] ? 1'b0 : (tsr_busy_reg ? tsr_reg[0] : 1'b1);
      irq_next = pend;
   end

   // registering of all state but the fifo storage; flags update after the read edge, so a set in that cycle survives
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         b_reg <= 1'b0;
         r_reg <= 1'b0;
         awa_reg <= 6'h00;
         wd_reg <= 32'h0;
         rd_reg <= 32'h0;
         bresp_reg <= ULCS_RESP_OKAY;
         rresp_reg <= ULCS_RESP_OKAY;
         lcr_reg <= ULCS_LCR_RST;
         ier_reg <= ULCS_IER_RST;
         div_reg <= ULCS_DIV_RST;
         fifo_en_reg <= 1'b0;
         tmo_reg <= 1'b0;
         ms_reg <= 1'b0;
         st_reg <= ulcs_status_t'(ULCS_LSR_RST);
         rbr_reg <= 8'h00;
         thr_reg <= 8'h00;
         tsr_reg <= 8'h00;
         thr_full_reg <= 1'b0;
         tsr_busy_reg <= 1'b0;
         holding_empty_flag_ack_reg <= 1'b0;
         so_reg <= 1'b1;
         irq_reg <= 1'b0;
         rp_reg <= '0;
         wp_reg <= '0;
         cnt_reg <= '0;
         errv_reg <= '0;
         txc_reg <= '0;
      end else begin
         aw_reg <= aw_next;
         w_reg <= w_next;
         b_reg <= b_next;
         r_reg <= r_next;
         awa_reg <= awa_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
         bresp_reg <= bresp_next;
         rresp_reg <= rresp_next;
         lcr_reg <= lcr_next;
         ier_reg <= ier_next;
         div_reg <= div_next;
         fifo_en_reg <= fifo_en_next;
         tmo_reg <= tmo_next;
         ms_reg <= ms_next;
         st_reg <= st_next;
         st_reg.fifo_err <= 1'b0;
         rbr_reg <= rbr_next;
         thr_reg <= thr_next;
         tsr_reg <= tsr_next;
         thr_full_reg <= thr_full_next;
         tsr_busy_reg <= tsr_busy_next;
         holding_empty_flag_ack_reg <= holding_empty_flag_ack_next;
         so_reg <= so_next;
         irq_reg <= irq_next;
         rp_reg <= rp_next;
         wp_reg <= wp_next;
         cnt_reg <= cnt_next;
         errv_reg <= fifo_push && push_err ? (errv_next | (DEPTH'(1) << wp_reg)) : errv_next;
         txc_reg <= txc_next;
      end
   end

   assign s_axi_awready = !aw_reg;
   assign s_axi_wready = !w_reg;
   assign s_axi_bvalid = b_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !r_reg;
   assign s_axi_rvalid = r_reg;
   assign s_axi_rdata = rd_reg;
   assign s_axi_rresp = rresp_reg;
   assign serial_out = so_reg;
   assign interrupt_output = irq_reg;

   // checks
   a_break_forces_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      lcr_reg[ULCS_LC_BRK] |=> !serial_out) else $error("break not low");
   a_ident_none_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
      (iir_rd && !pend) |=> s_axi_rdata[0]) else $error("ident bit0 wrong");
   a_ident_top_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
      iir_rd |=> s_axi_rdata[5:4] == 2'b00 && s_axi_rdata[7] == $past(fifo_en_reg)) else $error("ident high bits");
   a_ls_priority: assert property (@(posedge sys_clk) disable iff (!rstn)
      (iir_rd && ls_pend) |=> s_axi_rdata[3:0] == ULCS_ID_LS) else $error("priority wrong");
   a_rdy_clear_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rbr_rd && !fifo_en_reg && !wr_fire) |=> !st_reg.rx_ready) else $error("ready not cleared");
   a_holding_empty_flag_on_write: assert property (@(posedge sys_clk) disable iff (!rstn)
      (wr_fire && awa_reg == ULCS_OFF_DATA && !lcr_reg[ULCS_LC_DIVISOR_ACCESS_SELECT] && !thr_full_reg)
      |=> !st_reg.holding_empty && !st_reg.tx_idle) else $error("holding flags");
   a_idle_implies_empty: assert property (@(posedge sys_clk) disable iff (!rstn)
      st_reg.tx_idle && !$past(wr_fire) |-> !tsr_busy_reg || $past(awa_reg) == ULCS_OFF_LSR) else $error("idle wrong");
   a_shift_finishes: assert property (@(posedge sys_clk) disable iff (!rstn)
      (tsr_busy_reg && txc_reg == '0) |=> !tsr_busy_reg) else $error("shift stuck");
   a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
      pend |=> interrupt_output) else $error("irq missing");
   c_lsr_read: cover property (@(posedge sys_clk) lsr_rd && st_reg.overrun);
   c_fifo_full: cover property (@(posedge sys_clk) cnt_reg == (AW+1)'(DEPTH));
   c_break_tx: cover property (@(posedge sys_clk) lcr_reg[ULCS_LC_BRK] && tsr_busy_reg);
endmodule : ulcs_line_ctrl

// *** ulcs_host_model.sv ***
// host bus model: axi4-lite master doing one write or one read at a time
`timescale 1ns/1ps
module ulcs_host_model (
   input wire logic sys_clk,
   output logic [5:0] s_axi_awaddr = 6'h00,
   output logic s_axi_awvalid = 1'b0,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata = 32'h0,
   output logic [3:0] s_axi_wstrb = 4'hF,
   output logic s_axi_wvalid = 1'b0,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready = 1'b0,
   output logic [5:0] s_axi_araddr = 6'h00,
   output logic s_axi_arvalid = 1'b0,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready = 1'b0
);
   // address and data offered together, each dropped at its own handshake edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // no cycle count assumed: waits for rvalid, the bench watchdog bounds a hang
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : ulcs_host_model

// *** test_uart_line_ctrl_status.sv ***
// testbench: register scenarios for the line control/status block
`timescale 1ns/1ps
module test_uart_line_ctrl_status;
   import ulcs_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   int checks = 0;
   int miscompares = 0;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, serial_out, interrupt_output;
   ulcs_line_ctrl #(.DEPTH(16), .AW(4)) i_ulcs_line_ctrl (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .serial_out, .interrupt_output);
   ulcs_host_model i_ulcs_host_model (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;
   // shared compare, read-and-compare and write helpers
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      i_ulcs_host_model.rd(a, d, r);
      cmp({6'h00, r}, {6'h00, ULCS_RESP_OKAY});
      cmp(d[7:0] & m, e);
   endtask : chk
   task automatic w(input logic [5:0] a, input logic [31:0] d);
      logic [1:0] r;
      i_ulcs_host_model.wr(a, d, r);
   endtask : w
   // steps the transmitter a bit time at a time until a status bit rises
   task automatic step_until(input logic [7:0] m, output logic ok);
      logic [31:0] d;
      logic [1:0] r;
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         i_ulcs_host_model.rd(ULCS_OFF_LSR, d, r);
         ok = (d[7:0] & m) != 8'h00;
         if (!ok) w(ULCS_OFF_TXCT, 32'h1);
      end
   endtask : step_until
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      chk(ULCS_OFF_LSR, 8'hFF, 8'h60);
      chk(ULCS_OFF_IDENT, 8'hFF, 8'h01);
      chk(ULCS_OFF_LCR, 8'hFF, ULCS_LCR_RST);
      i_ulcs_host_model.rd(6'h3C, d, r);
      cmp({6'h00, r}, {6'h00, ULCS_RESP_SLVERR});
      $display("done: reset");
   endtask : t_reset
   task automatic t_lcr;
      w(ULCS_OFF_LCR, 32'hBF);
      chk(ULCS_OFF_LCR, 8'hFF, 8'hBF);
      w(ULCS_OFF_DATA, 32'h5A);
      w(ULCS_OFF_IEN, 32'h3C);
      chk(ULCS_OFF_DATA, 8'hFF, 8'h5A);
      chk(ULCS_OFF_IEN, 8'hFF, 8'h3C);
      w(ULCS_OFF_LCR, 32'h03);
      chk(ULCS_OFF_IEN, 8'hFF, ULCS_IER_RST);
      chk(ULCS_OFF_LSR, 8'hFF, 8'h60);
      $display("done: line control");
   endtask : t_lcr
   task automatic t_rx;
      w(ULCS_OFF_RXIN, 32'h2A5);
      chk(ULCS_OFF_LSR, 8'h03, 8'h01);
      w(ULCS_OFF_RXIN, 32'h23C);
      chk(ULCS_OFF_LSR, 8'h03, 8'h03);
      chk(ULCS_OFF_LSR, 8'h03, 8'h01);
      chk(ULCS_OFF_DATA, 8'hFF, 8'h3C);
      chk(ULCS_OFF_LSR, 8'h01, 8'h00);
      $display("done: receive");
   endtask : t_rx
   // one received character per line setting; parity, stop and break cases
   task automatic t_err;
      logic [7:0] lc [7] = '{8'h1B, 8'h0B, 8'h3B, 8'h07, 8'h03, 8'h03, 8'h18};
      logic [15:0] inj [7] = '{16'h201, 16'h301, 16'h201, 16'h201, 16'h001, 16'h400, 16'h2E1};
      logic [7:0] mk [7] = '{8'h0C, 8'h0C, 8'h0C, 8'h08, 8'h08, 8'h10, 8'h0C};
      logic [7:0] ex [7] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h08, 8'h10, 8'h04};
      // data after word-length masking; a break stores one zero character
      logic [7:0] dx [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
      w(ULCS_OFF_IEN, 32'h05);
      for (int i = 0; i < 7; i++) begin
         w(ULCS_OFF_LCR, {24'h0, lc[i]});
         w(ULCS_OFF_RXIN, {16'h0, inj[i]});
         repeat (3) @(negedge sys_clk);
         cmp({7'h00, interrupt_output}, 8'h01);
         chk(ULCS_OFF_IDENT, 8'hFF, (ex[i] != 8'h00) ? 8'h06 : 8'h04);
         chk(ULCS_OFF_LSR, mk[i], ex[i]);
         chk(ULCS_OFF_DATA, 8'hFF, dx[i]);
      end
      $display("done: receive errors");
   endtask : t_err
   task automatic t_fifo;
      w(ULCS_OFF_IDENT, 32'h01);
      w(ULCS_OFF_IEN, 32'h01);
      chk(ULCS_OFF_IDENT, 8'hF0, 8'hC0);
      w(ULCS_OFF_LCR, 32'h1B);
      w(ULCS_OFF_RXIN, 32'h201);
      chk(ULCS_OFF_LSR, 8'h80, 8'h80);
      w(ULCS_OFF_RXIN, 32'hA41);
      chk(ULCS_OFF_IDENT, 8'hFF, 8'hCC);
      chk(ULCS_OFF_DATA, 8'hFF, 8'h01);
      chk(ULCS_OFF_DATA, 8'hFF, 8'h41);
      // fill the fifo, then one more: the extra character must be dropped
      for (int i = 0; i < 16; i++) w(ULCS_OFF_RXIN, 32'h200);
      w(ULCS_OFF_RXIN, 32'h2FF);
      chk(ULCS_OFF_LSR, 8'h03, 8'h03);
      for (int i = 0; i < 16; i++) chk(ULCS_OFF_DATA, 8'hFF, 8'h00);
      chk(ULCS_OFF_LSR, 8'h03, 8'h00);
      w(ULCS_OFF_IDENT, 32'h00);
      chk(ULCS_OFF_IDENT, 8'hFF, 8'h01);
      chk(ULCS_OFF_LSR, 8'h80, 8'h00);
      $display("done: fifo mode");
   endtask : t_fifo
   // holding-empty interrupt, then a break sent the safe way
   task automatic t_tx;
      logic ok;
      w(ULCS_OFF_LCR, 32'h03);
      w(ULCS_OFF_IEN, 32'h02);
      repeat (3) @(negedge sys_clk);
      cmp({7'h00, interrupt_output}, 8'h01);
      chk(ULCS_OFF_IDENT, 8'hFF, 8'h02);
      repeat (3) @(negedge sys_clk);
      cmp({7'h00, interrupt_output}, 8'h00);
      w(ULCS_OFF_DATA, 32'h00);
      chk(ULCS_OFF_LSR, 8'h40, 8'h00);
      step_until(8'h20, ok);
      cmp({7'h00, ok}, 8'h01);
      w(ULCS_OFF_LCR, 32'h43);
      repeat (3) @(negedge sys_clk);
      cmp({7'h00, serial_out}, 8'h00);
      step_until(8'h40, ok);
      cmp({7'h00, ok}, 8'h01);
      w(ULCS_OFF_LCR, 32'h03);
      repeat (3) @(negedge sys_clk);
      cmp({7'h00, serial_out}, 8'h01);
      // second byte waits in holding while the first shifts; idle only after both
      w(ULCS_OFF_DATA, 32'h55);
      w(ULCS_OFF_DATA, 32'hAA);
      chk(ULCS_OFF_LSR, 8'h60, 8'h00);
      step_until(8'h40, ok);
      cmp({7'h00, ok}, 8'h01);
      $display("done: transmit");
   endtask : t_tx
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // main sequence after a 12-cycle reset
   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_lcr();
      t_rx();
      t_err();
      t_fifo();
      t_tx();
      print_verdict();
   end
   // watchdog: whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      print_verdict();
   end
endmodule : test_uart_line_ctrl_status
